// ---- design/dtg_pkg.sv ----
`default_nettype none
package dtg_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] DTG_OFS_TRIG    = 8'h00;
   localparam logic [7:0] DTG_OFS_STAT    = 8'h04;
   localparam logic [7:0] DTG_OFS_CTRL    = 8'h08;
   localparam logic [7:0] DTG_OFS_FIFO_LO = 8'h0c;
   localparam logic [7:0] DTG_OFS_FIFO_HI = 8'h10;

   // trace_trigger_config fields
   localparam int         DTG_TRIG_TYPE_BIT  = 7;
   localparam int         DTG_TRIG_BEGIN_BIT = 6;
   localparam logic [7:0] DTG_TRIG_WR_MASK   = 8'hcf;
   localparam logic [7:0] DTG_TRIG_RST       = 8'h00;

   // trace_run_status fields
   localparam int         DTG_STAT_AF_BIT   = 7;
   localparam int         DTG_STAT_BF_BIT   = 6;
   localparam int         DTG_STAT_ARMED_FLAG_BIT = 5;

   // trace_control_register fields
   localparam int         DTG_CTRL_EN_BIT  = 7;
   localparam int         DTG_CTRL_ARM_BIT = 6;
   localparam int         DTG_CTRL_TAG_BIT = 5;
   localparam int         DTG_CTRL_BRK_BIT = 4;
   localparam logic [7:0] DTG_CTRL_RST     = 8'h00;

   // trigger mode codes
   localparam logic [3:0] DTG_MODE_A_ONLY     = 4'h0;
   localparam logic [3:0] DTG_MODE_A_OR_B     = 4'h1;
   localparam logic [3:0] DTG_MODE_A_THEN_B   = 4'h2;
   localparam logic [3:0] DTG_MODE_EVENT_B    = 4'h3;
   localparam logic [3:0] DTG_MODE_A_EVENT_B  = 4'h4;
   localparam logic [3:0] DTG_MODE_A_AND_BD   = 4'h5;
   localparam logic [3:0] DTG_MODE_A_NOT_BD   = 4'h6;
   localparam logic [3:0] DTG_MODE_INSIDE     = 4'h7;
   localparam logic [3:0] DTG_MODE_OUTSIDE    = 4'h8;

   // trace buffer depth and count width
   localparam int         DTG_FIFO_DEPTH = 8;
   localparam int         DTG_CNT_W      = 4;

   // hit vector positions
   localparam int         DTG_HIT_A   = 0;
   localparam int         DTG_HIT_B   = 1;
   localparam int         DTG_HIT_BD  = 2;
   localparam int         DTG_HIT_IN  = 3;
   localparam int         DTG_HIT_OUT = 4;
   localparam int         DTG_HIT_W   = 5;

   typedef enum logic [1:0] {
      DTG_ST_IDLE,
      DTG_ST_WAIT,
      DTG_ST_STORE
   } dtg_run_t;
endpackage
`default_nettype wire

// ---- design/dtg_trigger_status.sv ----
// Notes on behaviour
// - trigger config writable only while disarmed
// - trigger config bits 5:4 read zero
// - tag mode triggers only on executed opcode
// - force mode triggers at access immediately
// - start select chooses end or begin trace
// - event-only modes always run as begin trace
// - modes 0-4: A, A|B, A>B, event B, A>event B
// - mode 5 A and B data, 6 A not B data
// - 7 inside, 8 outside range, 9-15 never
// - A flag cleared at start, set on A match
// - B flag cleared at start, set on B match
// - armed flag mirrors arm control while enabled
// - run ends at begin-trace full or end-trace trigger
// - writing arm or enable 0 ends run
// - count cleared at start, reports words at end
// - count unchanged while fifo is read out
// - status register is read-only
// - low byte read advances fifo, high does not
// - break request at end trigger or begin-trace full
`default_nettype none
module dtg_trigger_status
   import dtg_pkg::*;
#(
   parameter int DEPTH = DTG_FIFO_DEPTH
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        access_i,
   input  wire logic        match_a_i,
   input  wire logic        match_b_i,
   input  wire logic        data_match_b_i,
   input  wire logic        addr_ge_a_i,
   input  wire logic        addr_le_b_i,
   input  wire logic [7:0]  access_data_i,
   input  wire logic        opcode_exec_i,
   input  wire logic        opcode_flush_i,
   input  wire logic        cof_valid_i,
   input  wire logic [15:0] cof_addr_i,
   input  wire logic [15:0] last_opcode_addr_i,
   output logic             armed_o,
   output logic             trigger_o,
   output logic             break_req_o,
   output logic             break_tag_o
);
   localparam int PTR_W = $clog2(DEPTH);

   // count field is four bits and pointers wrap by width
   if (DEPTH != 2 && DEPTH != 4 && DEPTH != 8) begin : g_depth_chk
      $error("dtg_trigger_status: DEPTH must be 2, 4 or 8");
   end

   logic [7:0]            trig_cfg;
   logic                  ctrl_en;
   logic                  ctrl_arm;
   logic                  ctrl_tag;
   logic                  ctrl_brk;
   logic                  flag_a;
   logic                  flag_b;
   logic [DTG_CNT_W-1:0]  valid_cnt;
   dtg_run_t              run_st;
   logic                  a_seen;
   logic [DTG_HIT_W-1:0]  pend;
   logic [DTG_HIT_W-1:0]  raw_hit;
   logic [DTG_HIT_W-1:0]  qhit;
   logic [15:0]           mem [DEPTH];
   logic [PTR_W-1:0]      wr_ptr;
   logic [PTR_W-1:0]      rd_ptr;
   logic [DTG_CNT_W-1:0]  fill;

   // bus decode; effects land on the edge that sees ack high
   logic       bus_req;
   logic       bus_fire;
   logic       wr_fire;
   logic       rd_fire;
   logic       wr_trig;
   logic       wr_ctrl;
   logic       rd_fifo_lo;
   assign bus_req    = wb_cyc_i & wb_stb_i;
   assign bus_fire   = bus_req & wb_ack_o;
   assign wr_fire    = bus_fire & wb_we_i & wb_sel_i[0];
   assign rd_fire    = bus_fire & ~wb_we_i;
   assign wr_trig    = wr_fire && wb_adr_i == DTG_OFS_TRIG;
   assign wr_ctrl    = wr_fire && wb_adr_i == DTG_OFS_CTRL;
   assign rd_fifo_lo = rd_fire && wb_adr_i == DTG_OFS_FIFO_LO;

   // trigger config decode
   logic [3:0] mode;
   logic       tag_sel;
   logic       event_mode;
   logic       begin_sel;
   assign mode       = trig_cfg[3:0];
   assign tag_sel    = trig_cfg[DTG_TRIG_TYPE_BIT];
   assign event_mode = mode == DTG_MODE_EVENT_B || mode == DTG_MODE_A_EVENT_B;
   assign begin_sel  = trig_cfg[DTG_TRIG_BEGIN_BIT] | event_mode;

   // raw comparator results of the current access
   assign raw_hit[DTG_HIT_A]   = match_a_i;
   assign raw_hit[DTG_HIT_B]   = match_b_i;
   assign raw_hit[DTG_HIT_BD]  = data_match_b_i;
   assign raw_hit[DTG_HIT_IN]  = addr_ge_a_i & addr_le_b_i;
   assign raw_hit[DTG_HIT_OUT] = ~(addr_ge_a_i & addr_le_b_i);

   // per-hit qualification: force passes at access, tag waits for execution
   for (genvar h = 0; h < DTG_HIT_W; h++) begin : g_qual
      assign qhit[h] = tag_sel ? (opcode_exec_i & pend[h])
                               : (access_i & raw_hit[h]);
      always_ff @(posedge clk_i) begin
         if (rst_i || run_st == DTG_ST_IDLE) begin
            pend[h] <= 1'b0;
         end else if (opcode_exec_i || opcode_flush_i) begin
            // a flushed prefetch never executed, so its match is dropped
            pend[h] <= 1'b0;
         end else if (access_i && raw_hit[h]) begin
            pend[h] <= 1'b1;
         end
      end
   end

   // mode decode into a single trigger event
   logic trig_hit;
   always_comb begin
      case (mode)
         DTG_MODE_A_ONLY:    trig_hit = qhit[DTG_HIT_A];
         DTG_MODE_A_OR_B:    trig_hit = qhit[DTG_HIT_A] | qhit[DTG_HIT_B];
         DTG_MODE_A_THEN_B:  trig_hit = a_seen & qhit[DTG_HIT_B];
         DTG_MODE_EVENT_B:   trig_hit = qhit[DTG_HIT_B];
         DTG_MODE_A_EVENT_B: trig_hit = a_seen & qhit[DTG_HIT_B];
         DTG_MODE_A_AND_BD:  trig_hit = qhit[DTG_HIT_A] & qhit[DTG_HIT_BD];
         DTG_MODE_A_NOT_BD:  trig_hit = qhit[DTG_HIT_A] & ~qhit[DTG_HIT_BD];
         DTG_MODE_INSIDE:    trig_hit = qhit[DTG_HIT_IN];
         DTG_MODE_OUTSIDE:   trig_hit = qhit[DTG_HIT_OUT];
         default:            trig_hit = 1'b0;
      endcase
   end

   // run control events
   logic run_start;
   logic trig_fire;
   logic store_ev;
   logic store_cof;
   logic do_store;
   logic full_next;
   logic done_trig;
   logic done_full;
   logic done_manual;
   logic run_end;
   assign run_start = wr_ctrl && !ctrl_arm && wb_dat_i[DTG_CTRL_EN_BIT]
                      && wb_dat_i[DTG_CTRL_ARM_BIT];
   assign trig_fire = run_st == DTG_ST_WAIT && trig_hit;
   // event modes store the access byte; high half stays zero
   assign store_ev  = event_mode && trig_hit && run_st != DTG_ST_IDLE;
   // end trace stores flow changes while waiting, begin trace after trigger
   assign store_cof = !event_mode && cof_valid_i
                      && ((run_st == DTG_ST_WAIT && !begin_sel)
                          || run_st == DTG_ST_STORE);
   assign do_store  = store_ev | store_cof;
   assign full_next = begin_sel && do_store && fill == DTG_CNT_W'(DEPTH - 1);
   assign done_trig = trig_fire && !begin_sel;
   assign done_full = full_next;
   assign done_manual = ctrl_arm && wr_ctrl && !(wb_dat_i[DTG_CTRL_EN_BIT]
                        && wb_dat_i[DTG_CTRL_ARM_BIT]);
   assign run_end   = run_st != DTG_ST_IDLE && (done_trig | done_full | done_manual);

   // run state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_st <= DTG_ST_IDLE;
      end else begin
         case (run_st)
            DTG_ST_IDLE: begin
               if (run_start) begin
                  run_st <= DTG_ST_WAIT;
               end
            end
            DTG_ST_WAIT: begin
               if (run_end) begin
                  run_st <= DTG_ST_IDLE;
               end else if (trig_fire && begin_sel) begin
                  run_st <= DTG_ST_STORE;
               end
            end
            DTG_ST_STORE: begin
               if (run_end) begin
                  run_st <= DTG_ST_IDLE;
               end
            end
            default: run_st <= DTG_ST_IDLE;
         endcase
      end
   end

   // sequence memory for the "A then B" modes
   always_ff @(posedge clk_i) begin
      if (rst_i || run_start) begin
         a_seen <= 1'b0;
      end else if (run_st != DTG_ST_IDLE && qhit[DTG_HIT_A]) begin
         a_seen <= 1'b1;
      end
   end

   // trigger config register; armed writes are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_cfg <= DTG_TRIG_RST;
      end else if (wr_trig && !ctrl_arm) begin
         trig_cfg <= wb_dat_i[7:0] & DTG_TRIG_WR_MASK;
      end
   end

   // control register; arm only holds while enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_en  <= DTG_CTRL_RST[DTG_CTRL_EN_BIT];
         ctrl_arm <= DTG_CTRL_RST[DTG_CTRL_ARM_BIT];
         ctrl_tag <= DTG_CTRL_RST[DTG_CTRL_TAG_BIT];
         ctrl_brk <= DTG_CTRL_RST[DTG_CTRL_BRK_BIT];
      end else if (wr_ctrl) begin
         ctrl_en  <= wb_dat_i[DTG_CTRL_EN_BIT];
         // a run that ends in the write cycle must not stay armed
         ctrl_arm <= wb_dat_i[DTG_CTRL_EN_BIT] & wb_dat_i[DTG_CTRL_ARM_BIT] & ~run_end;
         ctrl_tag <= wb_dat_i[DTG_CTRL_TAG_BIT];
         ctrl_brk <= wb_dat_i[DTG_CTRL_BRK_BIT];
      end else if (run_end) begin
         ctrl_arm <= 1'b0;
      end
   end

   // match flags; start only happens disarmed, so it never meets a set
   always_ff @(posedge clk_i) begin
      if (rst_i || run_start) begin
         flag_a <= 1'b0;
         flag_b <= 1'b0;
      end else if (run_st != DTG_ST_IDLE) begin
         if (qhit[DTG_HIT_A]) begin
            flag_a <= 1'b1;
         end
         if (qhit[DTG_HIT_B] | qhit[DTG_HIT_BD]) begin
            flag_b <= 1'b1;
         end
      end
   end

   // valid count: latched only at run end, so readout leaves it alone
   always_ff @(posedge clk_i) begin
      if (rst_i || run_start) begin
         valid_cnt <= '0;
      end else if (run_end) begin
         valid_cnt <= full_next ? DTG_CNT_W'(DEPTH) : fill;
      end
   end

   // fill level and pointers; circular end trace saturates at depth
   always_ff @(posedge clk_i) begin
      if (rst_i || run_start) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else if (do_store && run_st != DTG_ST_IDLE) begin
         wr_ptr <= wr_ptr + PTR_W'(1);
         if (fill != DTG_CNT_W'(DEPTH)) begin
            fill <= fill + DTG_CNT_W'(1);
         end
      end else if (run_end) begin
         // point the reader at the oldest stored word
         rd_ptr <= wr_ptr - fill[PTR_W-1:0];
      end else if (rd_fifo_lo && run_st == DTG_ST_IDLE) begin
         // reads while armed do not advance the buffer
         rd_ptr <= rd_ptr + PTR_W'(1);
      end
   end

   // trace storage; disarmed low reads refill the slot just read for profiling
   always_ff @(posedge clk_i) begin
      if (run_st != DTG_ST_IDLE && do_store) begin
         mem[wr_ptr] <= store_ev ? {8'h00, access_data_i} : cof_addr_i;
      end else if (run_st == DTG_ST_IDLE && rd_fifo_lo) begin
         mem[rd_ptr] <= last_opcode_addr_i;
      end
   end

   // side outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         armed_o     <= 1'b0;
         trigger_o   <= 1'b0;
         break_req_o <= 1'b0;
         break_tag_o <= 1'b0;
      end else begin
         armed_o     <= ctrl_arm;
         trigger_o   <= trig_fire;
         // break timing is the same for tag and force qualification
         break_req_o <= ctrl_brk && (done_trig || done_full);
         break_tag_o <= ctrl_tag;
      end
   end

   // read data mux; status has no write path at all
   logic [7:0] next_rdata;
   always_comb begin
      case (wb_adr_i)
         DTG_OFS_TRIG:    next_rdata = trig_cfg;
         DTG_OFS_STAT:    next_rdata = {flag_a, flag_b, ctrl_en & ctrl_arm, 1'b0,
                                        valid_cnt};
         DTG_OFS_CTRL:    next_rdata = {ctrl_en, ctrl_arm, ctrl_tag, ctrl_brk, 4'h0};
         DTG_OFS_FIFO_LO: next_rdata = mem[rd_ptr][7:0];
         DTG_OFS_FIFO_HI: next_rdata = mem[rd_ptr][15:8];
         default:         next_rdata = 8'h00;
      endcase
   end

   // single-wait-state slave; unmapped addresses ack with zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req && !wb_ack_o) begin
            wb_dat_o <= {24'h00_0000, next_rdata};
         end
      end
   end

   // checks
   property p_cfg_locked;
      @(posedge clk_i) disable iff (rst_i)
      (wr_trig && ctrl_arm) |=> $stable(trig_cfg);
   endproperty
   a_cfg_locked: assert property (p_cfg_locked)
      else $error("trigger config changed while armed");

   property p_cfg_hole;
      @(posedge clk_i) disable iff (rst_i)
      wr_trig && !ctrl_arm |=> trig_cfg[5:4] == 2'b00 && trig_cfg[7:6] == $past(wb_dat_i[7:6]);
   endproperty
   a_cfg_hole: assert property (p_cfg_hole)
      else $error("trigger config write stored wrong bits");

   property p_tag_waits;
      @(posedge clk_i) disable iff (rst_i)
      (tag_sel && !opcode_exec_i) |-> !trig_fire;
   endproperty
   a_tag_waits: assert property (p_tag_waits)
      else $error("tag trigger without executed opcode");

   property p_force_now;
      @(posedge clk_i) disable iff (rst_i)
      (run_st == DTG_ST_WAIT && !tag_sel && mode == DTG_MODE_A_ONLY && access_i && match_a_i)
      |=> trigger_o;
   endproperty
   a_force_now: assert property (p_force_now)
      else $error("force trigger missed");

   property p_event_begin;
      @(posedge clk_i) disable iff (rst_i)
      (event_mode && trig_fire && !full_next && !done_manual) |=> run_st == DTG_ST_STORE;
   endproperty
   a_event_begin: assert property (p_event_begin)
      else $error("event mode did not run as begin trace");

   property p_no_trig_high;
      @(posedge clk_i) disable iff (rst_i)
      mode > DTG_MODE_OUTSIDE |=> !trigger_o;
   endproperty
   a_no_trig_high: assert property (p_no_trig_high)
      else $error("reserved mode triggered");

   property p_start_clears;
      @(posedge clk_i) disable iff (rst_i)
      run_start |=> !flag_a && !flag_b && valid_cnt == 4'h0 && ctrl_arm;
   endproperty
   a_start_clears: assert property (p_start_clears)
      else $error("run start did not clear status");

   property p_end_trace_stop;
      @(posedge clk_i) disable iff (rst_i)
      done_trig |=> !ctrl_arm ##1 !armed_o;
   endproperty
   a_end_trace_stop: assert property (p_end_trace_stop)
      else $error("end trace kept running after trigger");

   property p_manual_stop;
      @(posedge clk_i) disable iff (rst_i)
      done_manual |=> run_st == DTG_ST_IDLE && !ctrl_arm;
   endproperty
   a_manual_stop: assert property (p_manual_stop)
      else $error("manual stop ignored");

   property p_cnt_hold;
      @(posedge clk_i) disable iff (rst_i)
      (run_st == DTG_ST_IDLE && rd_fifo_lo && !run_start) |=> $stable(valid_cnt);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("count moved during readout");

   property p_fifo_adv;
      @(posedge clk_i) disable iff (rst_i)
      (run_st == DTG_ST_IDLE && rd_fifo_lo && !run_start) |=> rd_ptr == $past(rd_ptr) + 1'b1;
   endproperty
   a_fifo_adv: assert property (p_fifo_adv)
      else $error("low byte read did not advance");

   property p_break;
      @(posedge clk_i) disable iff (rst_i)
      (ctrl_brk && (done_trig || done_full)) |=> break_req_o;
   endproperty
   a_break: assert property (p_break)
      else $error("break request missing");

   c_end_trace:   cover property (@(posedge clk_i) disable iff (rst_i) done_trig);
   c_begin_full:  cover property (@(posedge clk_i) disable iff (rst_i) done_full && !event_mode);
   c_event_full:  cover property (@(posedge clk_i) disable iff (rst_i) done_full && event_mode);
   c_manual_stop: cover property (@(posedge clk_i) disable iff (rst_i) done_manual);
endmodule
`default_nettype wire

// ---- test/dtg_cpu_model.sv ----
`default_nettype none
module dtg_cpu_model
   import dtg_pkg::*;
(
   input  wire logic        clk_i,
   output logic             access_o,
   output logic             match_a_o,
   output logic             match_b_o,
   output logic             data_match_b_o,
   output logic             addr_ge_a_o,
   output logic             addr_le_b_o,
   output logic [7:0]       access_data_o,
   output logic             opcode_exec_o,
   output logic             opcode_flush_o,
   output logic             cof_valid_o,
   output logic [15:0]      cof_addr_o,
   output logic [15:0]      last_opcode_addr_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] fetch_addr;

   // quiet bus at time zero
   initial begin
      {access_o, match_a_o, match_b_o, data_match_b_o, addr_ge_a_o, addr_le_b_o} = '0;
      {opcode_exec_o, opcode_flush_o, cof_valid_o} = '0;
      access_data_o = 8'h00;
      cof_addr_o = 16'h0000;
      fetch_addr = 16'h0000;
   end

   assign last_opcode_addr_o = fetch_addr;

   // one access, h = {le_b, ge_a, data_b, b, a}; lines are junk outside it
   task automatic hit(input logic [4:0] h, input logic [7:0] d);
      access_o <= 1'b1;
      {addr_le_b_o, addr_ge_a_o, data_match_b_o, match_b_o, match_a_o} <= h;
      access_data_o <= d;
      @(posedge clk_i);
      access_o <= 1'b0;
      {addr_le_b_o, addr_ge_a_o, data_match_b_o, match_b_o, match_a_o} <= ~h;
      access_data_o <= ~d;
      @(posedge clk_i);
   endtask

   // one pulse, k = {cof, flush, exec}; address is junk afterwards
   task automatic pulse(input logic [2:0] k, input logic [15:0] a);
      {cof_valid_o, opcode_flush_o, opcode_exec_o} <= k;
      cof_addr_o <= a;
      fetch_addr <= a;
      @(posedge clk_i);
      {cof_valid_o, opcode_flush_o, opcode_exec_o} <= 3'b000;
      cof_addr_o <= ~a;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ---- test/dtg_trigger_status_tb.sv ----
`default_nettype none
module dtg_trigger_status_tb
   import dtg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, armed_o, trigger_o, break_req_o, btag;
   wire         acc, ma, mb, mbd, ge, le, ex, fl, cv;
   wire  [7:0]  ad;
   wire  [15:0] ca, la;
   int          n_errors = 0;
   int          num_checks = 0;
   int          n_trig = 0;
   int          n_brk = 0;
   int          t0, b0;

   always #12.5 clk_i = ~clk_i;

   dtg_trigger_status #(.DEPTH(DTG_FIFO_DEPTH)) i_dtg_trigger_status (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .access_i(acc), .match_a_i(ma),
      .match_b_i(mb), .data_match_b_i(mbd), .addr_ge_a_i(ge), .addr_le_b_i(le),
      .access_data_i(ad), .opcode_exec_i(ex), .opcode_flush_i(fl), .cof_valid_i(cv),
      .cof_addr_i(ca), .last_opcode_addr_i(la), .armed_o(armed_o), .trigger_o(trigger_o),
      .break_req_o(break_req_o), .break_tag_o(btag));

   dtg_cpu_model i_dtg_cpu_model (
      .clk_i(clk_i), .access_o(acc), .match_a_o(ma), .match_b_o(mb), .data_match_b_o(mbd),
      .addr_ge_a_o(ge), .addr_le_b_o(le), .access_data_o(ad), .opcode_exec_o(ex),
      .opcode_flush_o(fl), .cof_valid_o(cv), .cof_addr_o(ca), .last_opcode_addr_o(la));

   // pulses are one cycle wide, so tally them at every edge
   always @(posedge clk_i) begin
      if (trigger_o === 1'b1) n_trig++;
      if (break_req_o === 1'b1) n_brk++;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // classic cycle; waits for ack, bounded so a dead slave cannot hang us
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'h1;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 16);
      // a missing ack counts against the run
      if (wb_ack_o !== 1'b1) chk("ack", 8'h01, {7'h0, wb_ack_o});
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(what, exp, q);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic t_reset;
      rdc("cfg", DTG_OFS_TRIG, 8'h00);
      rdc("stat", DTG_OFS_STAT, 8'h00);
      rdc("unmapped", 8'h14, 8'h00);
      wr(DTG_OFS_TRIG, 8'hff);
      rdc("cfg mask", DTG_OFS_TRIG, 8'hcf);
      wr(DTG_OFS_CTRL, 8'hc0);
      wr(DTG_OFS_TRIG, 8'h00);
      rdc("cfg armed", DTG_OFS_TRIG, 8'hcf);
      rdc("armed stat", DTG_OFS_STAT, 8'h20);
      t0 = n_trig;
      i_dtg_cpu_model.hit(5'h1f, 8'h5a);
      idle(3);
      chk("mode f", 8'h00, 8'(n_trig - t0));
      wr(DTG_OFS_CTRL, 8'h00);
      idle(1);
      chk("armed_o", 8'h00, {7'h0, armed_o});
   endtask

   // access at A, inside the range, no B data: only some modes fire
   task automatic t_modes;
      logic [15:0] fires;
      fires = 16'h00c3;
      for (int m = 0; m < 16; m++) begin
         wr(DTG_OFS_TRIG, {4'h0, 4'(m)});
         wr(DTG_OFS_CTRL, 8'hc0);
         t0 = n_trig;
         i_dtg_cpu_model.hit(5'h19, 8'h00);
         idle(3);
         chk("mode", {7'h0, fires[m]}, 8'(n_trig - t0));
         if (m == 2) begin
            i_dtg_cpu_model.hit(5'h02, 8'h00);
            idle(3);
            chk("a then b", 8'h01, 8'(n_trig - t0));
         end
         wr(DTG_OFS_CTRL, 8'h80);
         idle(1);
         chk("disarm", 8'h00, {7'h0, armed_o});
      end
   endtask

   task automatic t_end;
      wr(DTG_OFS_TRIG, 8'h00);
      wr(DTG_OFS_CTRL, 8'hd0);
      rdc("run start", DTG_OFS_STAT, 8'h20);
      for (int i = 0; i < 3; i++) i_dtg_cpu_model.pulse(3'b100, {8'(8'h11 * (i + 1)), 8'(8'h81 + i)});
      t0 = n_trig;
      b0 = n_brk;
      i_dtg_cpu_model.hit(5'h01, 8'h00);
      idle(3);
      chk("force trig", 8'h01, 8'(n_trig - t0));
      chk("end brk", 8'h01, 8'(n_brk - b0));
      chk("end armed", 8'h00, {7'h0, armed_o});
      chk("break_tag_o", 8'h00, {7'h0, btag});
      rdc("end stat", DTG_OFS_STAT, 8'h83);
      wr(DTG_OFS_STAT, 8'h00);
      rdc("ro stat", DTG_OFS_STAT, 8'h83);
      // host tallies its own reads, the count stays put
      for (int i = 0; i < 3; i++) begin
         rdc("hi", DTG_OFS_FIFO_HI, 8'(8'h11 * (i + 1)));
         rdc("hi again", DTG_OFS_FIFO_HI, 8'(8'h11 * (i + 1)));
         rdc("lo", DTG_OFS_FIFO_LO, 8'(8'h81 + i));
      end
      rdc("count kept", DTG_OFS_STAT, 8'h83);
   endtask

   task automatic t_begin;
      wr(DTG_OFS_TRIG, 8'h40);
      wr(DTG_OFS_CTRL, 8'hd0);
      t0 = n_trig;
      b0 = n_brk;
      i_dtg_cpu_model.hit(5'h01, 8'h00);
      for (int i = 0; i < 7; i++) i_dtg_cpu_model.pulse(3'b100, 16'(16'h4000 + i));
      rdc("filling", DTG_OFS_STAT, 8'ha0);
      chk("no brk yet", 8'h00, 8'(n_brk - b0));
      i_dtg_cpu_model.pulse(3'b100, 16'h4007);
      idle(3);
      chk("begin trig", 8'h01, 8'(n_trig - t0));
      chk("full brk", 8'h01, 8'(n_brk - b0));
      chk("full armed", 8'h00, {7'h0, armed_o});
      rdc("full stat", DTG_OFS_STAT, 8'h88);
   endtask

   // begin bit left at 0, event mode still stores after each B
   task automatic t_event;
      wr(DTG_OFS_TRIG, 8'h03);
      wr(DTG_OFS_CTRL, 8'hc0);
      for (int i = 0; i < 8; i++) i_dtg_cpu_model.hit(5'h02, 8'(8'h30 + i));
      idle(3);
      rdc("event stat", DTG_OFS_STAT, 8'h48);
      rdc("event lo", DTG_OFS_FIFO_LO, 8'h30);
   endtask

   task automatic t_tag;
      wr(DTG_OFS_TRIG, 8'h80);
      wr(DTG_OFS_CTRL, 8'hf0);
      t0 = n_trig;
      b0 = n_brk;
      i_dtg_cpu_model.hit(5'h01, 8'h00);
      idle(3);
      chk("tag waits", 8'h00, 8'(n_trig - t0));
      i_dtg_cpu_model.pulse(3'b010, 16'h0000);
      i_dtg_cpu_model.pulse(3'b001, 16'h0000);
      idle(3);
      chk("tag flushed", 8'h00, 8'(n_trig - t0));
      i_dtg_cpu_model.hit(5'h01, 8'h00);
      i_dtg_cpu_model.pulse(3'b001, 16'h0000);
      idle(3);
      chk("tag exec", 8'h01, 8'(n_trig - t0));
      chk("tag brk", 8'h01, 8'(n_brk - b0));
      chk("break_tag_o", 8'h01, {7'h0, btag});
   endtask

   // enable off with arm set ends the run; reset in mid-run clears arm, config and status
   task automatic t_rerst;
      wr(DTG_OFS_CTRL, 8'hc0);
      wr(DTG_OFS_CTRL, 8'h40);
      idle(1);
      chk("en off", 8'h00, {7'h0, armed_o});
      wr(DTG_OFS_CTRL, 8'hc0);
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      idle(1);
      chk("rst armed_o", 8'h00, {7'h0, armed_o});
      rdc("rst cfg", DTG_OFS_TRIG, 8'h00);
      rdc("rst stat", DTG_OFS_STAT, 8'h00);
   endtask

   task automatic final_report;
      if (n_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // watchdog, well past the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      idle(1);
      t_reset();
      t_modes();
      t_end();
      t_begin();
      t_event();
      t_tag();
      t_rerst();
      final_report();
   end
endmodule
`default_nettype wire
